//--- mifb_pkg.sv
// shared constants and types for the interrupt flag and enable bank
package mifb_pkg;

  // register indices on the plain register port
  localparam logic [2:0] MIFB_ADDR_EDGE = 3'h0; // external_edge_select
  localparam logic [2:0] MIFB_ADDR_CTL0 = 3'h1; // irq_control_zero
  localparam logic [2:0] MIFB_ADDR_CTL1 = 3'h2; // irq_control_one
  localparam logic [2:0] MIFB_ADDR_CTL2 = 3'h3; // irq_control_two
  localparam logic [2:0] MIFB_ADDR_GRP0 = 3'h4; // group_zero_sources
  localparam logic [2:0] MIFB_ADDR_GRP1 = 3'h5; // group_one_sources
  localparam logic [2:0] MIFB_ADDR_GRP2 = 3'h6; // group_two_sources
  localparam logic [2:0] MIFB_ADDR_STAT = 3'h7; // sticky event status
  localparam logic [2:0] MIFB_ADDR_MASK = 3'h0; // mask, on mask page

  // writable bit masks, unimplemented bits read zero
  localparam logic [7:0] MIFB_EDGE_WMASK = 8'h0F;
  localparam logic [7:0] MIFB_CTL0_WMASK = 8'h7F;
  localparam logic [7:0] MIFB_FULL_WMASK = 8'hFF;
  localparam logic [7:0] MIFB_GRP_WMASK  = 8'h33;
  localparam logic [7:0] MIFB_RESET_VAL  = 8'h00;

  // field positions in irq_control_zero
  localparam int MIFB_GIE_BIT  = 0;
  localparam int MIFB_P0E_BIT  = 1;
  localparam int MIFB_CMPE_BIT = 2;
  localparam int MIFB_G0E_BIT  = 3;
  localparam int MIFB_P0F_BIT  = 4;
  localparam int MIFB_CMPF_BIT = 5;
  localparam int MIFB_G0F_BIT  = 6;
  // flags sit four bits above their enables in the full registers
  localparam int MIFB_FLAG_OFS = 4;
  // pin edge field positions
  localparam int MIFB_PIN0_LSB = 0;
  localparam int MIFB_PIN1_LSB = 2;

  // edge select encodings
  localparam logic [1:0] MIFB_EDGE_OFF  = 2'h0;
  localparam logic [1:0] MIFB_EDGE_RISE = 2'h1;
  localparam logic [1:0] MIFB_EDGE_FALL = 2'h2;
  localparam logic [1:0] MIFB_EDGE_BOTH = 2'h3;

  // request vector line numbers toward the core
  localparam int MIFB_NREQ = 11;

  // peripheral event pulses, one cycle each
  typedef struct packed {
    logic comparator;
    logic converter;
    logic timebase0;
    logic timebase1;
    logic serial_iface;
    logic serial_async;
    logic timer0_cmpa;
    logic timer0_cmpp;
    logic timer1_cmpa;
    logic timer1_cmpp;
    logic periodic_timer_cmpa;
    logic periodic_timer_cmpp;
    logic eeprom_done;
    logic low_voltage;
  } mifb_events_s;

  // request lines, index order of the core's vectors
  typedef enum logic [3:0] {
    MIFB_V_PIN0, MIFB_V_CMP, MIFB_V_G0, MIFB_V_G1, MIFB_V_G2,
    MIFB_V_CONV, MIFB_V_TB0, MIFB_V_TB1, MIFB_V_SIFC, MIFB_V_SASY,
    MIFB_V_PIN1
  } mifb_vec_e;

endpackage : mifb_pkg

//--- mifb_edge_det.sv
// edge detector for one external interrupt pin
`timescale 1ns/100ps
module mifb_edge_det
  import mifb_pkg::*;
(
  input  wire logic       i_sys_clk, // system clock
  input  wire logic       i_rstn,    // async reset, active low
  input  wire logic       i_pin,     // pin level, synchronous
  input  wire logic [1:0] i_sel,     // edge field
  output logic            o_hit      // selected edge seen
);

  logic pin_q; // previous pin level

  // previous sample, resets low so a high pin after reset reads rising
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= i_pin;
    end
  end

  // decode the edge field
  always_comb begin
    case (i_sel)
      MIFB_EDGE_RISE: o_hit = i_pin & ~pin_q;
      MIFB_EDGE_FALL: o_hit = ~i_pin & pin_q;
      MIFB_EDGE_BOTH: o_hit = i_pin ^ pin_q;
      default:        o_hit = 1'b0; // disabled
    endcase
  end

endmodule : mifb_edge_det

//--- mifb_flag_reg.sv
// one request register: four flags over four enables
`timescale 1ns/100ps
module mifb_flag_reg
  import mifb_pkg::*;
(
  input  wire logic       i_sys_clk, // system clock
  input  wire logic       i_rstn,    // async reset, active low
  input  wire logic [7:0] i_wmask,   // implemented bits
  input  wire logic       i_wr,      // software write
  input  wire logic [7:0] i_wdata,   // write data
  input  wire logic [3:0] i_set,     // hardware flag sets
  input  wire logic [3:0] i_clr,     // service clears
  output logic      [7:0] o_value    // register contents
);

  logic [7:0] reg_q; // flags high nibble, enables low
  logic [7:0] reg_d; // next value

  // software write first, then clears, hardware set wins over both
  always_comb begin
    reg_d = reg_q;
    if (i_wr) begin
      reg_d = i_wdata;
    end
    reg_d[7:4] = (reg_d[7:4] & ~i_clr) | i_set;
    reg_d = reg_d & i_wmask;
  end

  // storage
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      reg_q <= MIFB_RESET_VAL;
    end else begin
      reg_q <= reg_d;
    end
  end

  assign o_value = reg_q;

endmodule : mifb_flag_reg

//--- mifb_bank.sv
// interrupt request flag and enable bank with register port
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/100ps
module mifb_bank
  import mifb_pkg::*;
(
  input  wire logic                 i_sys_clk, // system clock
  input  wire logic                 i_rstn,    // async reset, active low
  input  wire logic [3:0]           i_addr,    // bit3 selects mask page
  input  wire logic [7:0]           i_wdata,   // write data
  input  wire logic                 i_wr,      // write strobe
  input  wire logic                 i_rd,      // read strobe
  output logic      [7:0]           o_rdata,   // read data, next cycle
  input  wire logic                 i_pin0,    // external pin 0
  input  wire logic                 i_pin1,    // external pin 1
  input  wire mifb_events_s         i_evt,     // peripheral pulses
  input  wire logic                 i_ack,     // core takes a vector
  input  wire logic [3:0]           i_ack_vec, // which vector
  output logic      [MIFB_NREQ-1:0] o_req,     // requests to core
  output logic                      o_irq      // masked status level
);

  logic [7:0] edge_q;    // edge select register
  logic [6:0] ctl0_q;    // control zero bits 6..0
  logic [7:0] ctl1_v;    // control one value
  logic [7:0] ctl2_v;    // control two value
  logic [7:0] grp0_v;    // group zero sources
  logic [7:0] grp1_v;    // group one sources
  logic [7:0] grp2_v;    // group two sources
  logic [7:0] stat_q;    // sticky event status
  logic [7:0] mask_q;    // status mask
  logic [7:0] rdata_q;   // read data register
  logic [MIFB_NREQ-1:0] req_q; // request lines
  logic       irq_q;     // interrupt level
  logic       hit0;      // pin0 edge seen
  logic       hit1;      // pin1 edge seen
  logic       page_m;    // mask page access
  logic [7:0] wr_dec;    // one-hot register write
  logic [3:0] set1;      // control one hw sets
  logic [3:0] set2;      // control two hw sets
  logic [3:0] clr1;      // control one service clears
  logic [3:0] clr2;      // control two service clears
  logic       g0_set;    // any group0 sub-flag newly set
  logic       g1_set;    // any group1 sub-flag newly set
  logic       g2_set;    // any group2 sub-flag newly set
  logic       svc;       // a vector is taken
  logic [7:0] evt_vec;   // status event vector
  logic [7:0] rd_mux;    // read selection

  assign page_m = i_addr[3];
  assign svc    = i_ack;

  mifb_edge_det u_edge0 (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_pin     (i_pin0),
    .i_sel     (edge_q[MIFB_PIN0_LSB +: 2]),
    .o_hit     (hit0)
  );

  mifb_edge_det u_edge1 (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_pin     (i_pin1),
    .i_sel     (edge_q[MIFB_PIN1_LSB +: 2]),
    .o_hit     (hit1)
  );

  // address decode to one write line per register
  always_comb begin
    wr_dec = 8'h00;
    // mask page writes reach the mask alone, so edge select keeps its bits
    if (i_wr && !page_m) begin
      wr_dec[i_addr[2:0]] = 1'b1;
    end
  end

  // group flag sets on any new sub-source set
  // routing of timer and eeprom/lvd sources
  assign g0_set = i_evt.timer0_cmpa | i_evt.timer0_cmpp;
  assign g1_set = i_evt.timer1_cmpa | i_evt.timer1_cmpp
                | i_evt.periodic_timer_cmpa
                | i_evt.periodic_timer_cmpp;
  assign g2_set = i_evt.eeprom_done | i_evt.low_voltage;

  // control one set order: tb0, conv, g2, g1
  assign set1 = {i_evt.timebase0, i_evt.converter, g2_set, g1_set};
  // control two set order: uart, serial, pin1, tb1
  assign set2 = {i_evt.serial_async, i_evt.serial_iface, hit1,
                 i_evt.timebase1};

  // service clears only the taken flag
  always_comb begin
    clr1 = 4'h0;
    clr2 = 4'h0;
    if (svc) begin
      case (i_ack_vec)
        MIFB_V_TB0:  clr1[3] = 1'b1;
        MIFB_V_CONV: clr1[2] = 1'b1;
        MIFB_V_G2:   clr1[1] = 1'b1;
        MIFB_V_G1:   clr1[0] = 1'b1;
        MIFB_V_SASY: clr2[3] = 1'b1;
        MIFB_V_SIFC: clr2[2] = 1'b1;
        MIFB_V_PIN1: clr2[1] = 1'b1;
        MIFB_V_TB1:  clr2[0] = 1'b1;
        default: begin
          clr1 = 4'h0;
          clr2 = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      edge_q <= MIFB_RESET_VAL;
    end else if (wr_dec[MIFB_ADDR_EDGE]) begin
      edge_q <= i_wdata & MIFB_EDGE_WMASK;
    end
  end

  // control zero: hand-built since bit 0 is the global enable
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctl0_q <= 7'h00;
    end else begin
      if (wr_dec[MIFB_ADDR_CTL0]) begin
        ctl0_q <= i_wdata[6:0];
      end
      if (svc) begin
        ctl0_q[MIFB_GIE_BIT] <= 1'b0;
        if (i_ack_vec == MIFB_V_PIN0) ctl0_q[MIFB_P0F_BIT]  <= 1'b0;
        if (i_ack_vec == MIFB_V_CMP)  ctl0_q[MIFB_CMPF_BIT] <= 1'b0;
        // group zero flag cleared on service
        if (i_ack_vec == MIFB_V_G0)   ctl0_q[MIFB_G0F_BIT]  <= 1'b0;
      end
      // hardware sets win over write and service
      if (hit0)                ctl0_q[MIFB_P0F_BIT]  <= 1'b1;
      if (i_evt.comparator)    ctl0_q[MIFB_CMPF_BIT] <= 1'b1;
      if (g0_set)              ctl0_q[MIFB_G0F_BIT]  <= 1'b1;
    end
  end

  mifb_flag_reg u_ctl1 (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_wmask   (MIFB_FULL_WMASK),
    .i_wr      (wr_dec[MIFB_ADDR_CTL1]),
    .i_wdata   (i_wdata),
    .i_set     (set1),
    .i_clr     (clr1),
    .o_value   (ctl1_v)
  );

  mifb_flag_reg u_ctl2 (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_wmask   (MIFB_FULL_WMASK),
    .i_wr      (wr_dec[MIFB_ADDR_CTL2]),
    .i_wdata   (i_wdata),
    .i_set     (set2),
    .i_clr     (clr2),
    .o_value   (ctl2_v)
  );

  // group zero sources, bits 7..6 and 3..2 absent
  // sub-flags are never cleared by service, only by software
  mifb_flag_reg u_grp0 (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_wmask   (MIFB_GRP_WMASK),
    .i_wr      (wr_dec[MIFB_ADDR_GRP0]),
    .i_wdata   (i_wdata),
    .i_set     ({2'b00, i_evt.timer0_cmpa, i_evt.timer0_cmpp}),
    .i_clr     (4'h0),
    .o_value   (grp0_v)
  );

  mifb_flag_reg u_grp1 (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_wmask   (MIFB_FULL_WMASK),
    .i_wr      (wr_dec[MIFB_ADDR_GRP1]),
    .i_wdata   (i_wdata),
    .i_set     ({i_evt.timer1_cmpa, i_evt.timer1_cmpp,
                 i_evt.periodic_timer_cmpa, i_evt.periodic_timer_cmpp}),
    .i_clr     (4'h0),
    .o_value   (grp1_v)
  );

  // group two sources: eeprom bit 5, low voltage bit 4
  mifb_flag_reg u_grp2 (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_wmask   (MIFB_GRP_WMASK),
    .i_wr      (wr_dec[MIFB_ADDR_GRP2]),
    .i_wdata   (i_wdata),
    .i_set     ({2'b00, i_evt.eeprom_done, i_evt.low_voltage}),
    .i_clr     (4'h0),
    .o_value   (grp2_v)
  );

  // sticky status: pins, service taken, group activity
  assign evt_vec = {3'h0, svc, g2_set, g1_set | g0_set, hit1, hit0};

  // status bits, write one to clear, new event wins
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stat_q <= MIFB_RESET_VAL;
    end else if (wr_dec[MIFB_ADDR_STAT]) begin
      stat_q <= (stat_q & ~i_wdata) | evt_vec;
    end else begin
      stat_q <= stat_q | evt_vec;
    end
  end

  // mask register on the mask page
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mask_q <= MIFB_RESET_VAL;
    end else if (i_wr && page_m && i_addr[2:0] == MIFB_ADDR_MASK) begin
      mask_q <= i_wdata;
    end
  end

  // request = flag & enable & global enable
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      req_q <= '0;
    end else begin
      req_q[MIFB_V_PIN0] <= ctl0_q[MIFB_P0F_BIT] & ctl0_q[MIFB_P0E_BIT];
      req_q[MIFB_V_CMP]  <= ctl0_q[MIFB_CMPF_BIT] & ctl0_q[MIFB_CMPE_BIT];
      req_q[MIFB_V_G0]   <= ctl0_q[MIFB_G0F_BIT] & ctl0_q[MIFB_G0E_BIT];
      req_q[MIFB_V_G1]   <= ctl1_v[4] & ctl1_v[0];
      req_q[MIFB_V_G2]   <= ctl1_v[5] & ctl1_v[1];
      req_q[MIFB_V_CONV] <= ctl1_v[6] & ctl1_v[2];
      req_q[MIFB_V_TB0]  <= ctl1_v[7] & ctl1_v[3];
      req_q[MIFB_V_TB1]  <= ctl2_v[4] & ctl2_v[0];
      req_q[MIFB_V_PIN1] <= ctl2_v[5] & ctl2_v[1];
      req_q[MIFB_V_SIFC] <= ctl2_v[6] & ctl2_v[2];
      req_q[MIFB_V_SASY] <= ctl2_v[7] & ctl2_v[3];
      // global enable off, or just taken, blocks all
      if (!ctl0_q[MIFB_GIE_BIT] || svc) begin
        req_q <= '0;
      end
    end
  end

  // interrupt level from masked status
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // read mux, unmapped reads as zero
  always_comb begin
    rd_mux = 8'h00;
    if (page_m) begin
      if (i_addr[2:0] == MIFB_ADDR_MASK) rd_mux = mask_q;
    end else if (i_addr[2:0] == MIFB_ADDR_EDGE) begin
      rd_mux = edge_q;
    end else if (i_addr[2:0] == MIFB_ADDR_CTL0) begin
      rd_mux = {1'b0, ctl0_q};
    end else if (i_addr[2:0] == MIFB_ADDR_CTL1) begin
      rd_mux = ctl1_v;
    end else if (i_addr[2:0] == MIFB_ADDR_CTL2) begin
      rd_mux = ctl2_v;
    end else if (i_addr[2:0] == MIFB_ADDR_GRP0) begin
      rd_mux = grp0_v;
    end else if (i_addr[2:0] == MIFB_ADDR_GRP1) begin
      rd_mux = grp1_v;
    end else if (i_addr[2:0] == MIFB_ADDR_GRP2) begin
      rd_mux = grp2_v;
    end else begin
      rd_mux = stat_q;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign o_rdata = rdata_q;
  assign o_req   = req_q;
  assign o_irq   = irq_q;

endmodule : mifb_bank

//--- mifb_bank_props.sv
// checker for the register port and request lines of the bank
`timescale 1ns/100ps
module mifb_bank_props
  import mifb_pkg::*;
(
  input  wire logic                 i_sys_clk, // system clock
  input  wire logic                 i_rstn,    // async reset, active low
  input  wire logic [3:0]           i_addr,    // register address
  input  wire logic [7:0]           i_wdata,   // write data
  input  wire logic                 i_wr,      // write strobe
  input  wire logic                 i_rd,      // read strobe
  input  wire logic [7:0]           o_rdata,   // read data
  input  wire logic                 i_ack,     // core takes a vector
  input  wire logic [MIFB_NREQ-1:0] o_req,     // requests to core
  input  wire logic                 o_irq      // masked status level
);
  logic       gie_q;  // shadow of the global enable
  logic [4:0] mask_q; // shadow of the status mask

  default clocking dc @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  // global enable shadow; a taken vector wins over a write
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gie_q <= 1'b0;
    end else if (i_ack) begin
      gie_q <= 1'b0;
    end else if (i_wr && i_addr == 4'h1) begin
      gie_q <= i_wdata[0];
    end
  end

  // mask shadow, only software writes it
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mask_q <= 5'h00;
    end else if (i_wr && i_addr == 4'h8) begin
      mask_q <= i_wdata[4:0];
    end
  end

  a_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("read data outside slot");
  a_req_needs_gie: assert property (
    !gie_q |=> o_req == '0) else $error("request with global enable off");
  a_ack_clears_req: assert property (
    i_ack |=> o_req == '0) else $error("request stands after service");
  a_edge_upper_zero: assert property (
    $past(i_rd) && $past(i_addr) == 4'h0 |-> o_rdata[7:4] == 4'h0)
    else $error("edge register upper bits set");
  a_ctl0_top_zero: assert property (
    $past(i_rd) && $past(i_addr) == 4'h1 |-> !o_rdata[7])
    else $error("control zero bit 7 set");
  a_grp_holes_zero: assert property (
    $past(i_rd) && ($past(i_addr) == 4'h4 || $past(i_addr) == 4'h6)
    |-> (o_rdata & 8'hCC) == 8'h00) else $error("group hole bits set");
  a_reset_quiet: assert property (
    $rose(i_rstn) |-> o_req == '0 && !o_irq) else $error("outputs after reset");
  a_irq_masked_off: assert property (
    mask_q == 5'h00 |=> !o_irq) else $error("interrupt with mask clear");

  c_service: cover property (i_ack ##1 o_req == '0);
  c_irq_high: cover property (o_irq);
  c_req_high: cover property (o_req != '0);
endmodule : mifb_bank_props

bind mifb_bank mifb_bank_props chk_u (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_ack(i_ack), .o_req(o_req), .o_irq(o_irq));

//--- mifb_core_model.sv
// model of the core that takes vectors from the request lines
`timescale 1ns/100ps
module mifb_core_model
  import mifb_pkg::*;
(
  input  wire logic                 i_sys_clk, // system clock
  input  wire logic                 i_rstn,    // async reset, active low
  input  wire logic [MIFB_NREQ-1:0] i_req,     // request lines
  input  wire logic                 i_en,      // core may take vectors
  input  wire logic [3:0]           i_delay,   // cycles before taking
  output logic                      o_ack,     // vector taken pulse
  output logic      [3:0]           o_ack_vec  // which vector
);
  logic [3:0] wait_q; // cycles waited on a request

  // lowest line wins, a fixed priority
  function automatic logic [3:0] first_line(input logic [10:0] r);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 10; k >= 0; k--) begin
      if (r[k]) begin
        n = 4'(k);
      end
    end
    return n;
  endfunction : first_line

  // one pulse per request; skip the edge after a pulse as lines drop late
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ack     <= 1'b0;
      o_ack_vec <= 4'h0;
      wait_q    <= 4'h0;
    end else begin
      o_ack <= 1'b0;
      if (!i_en || i_req == '0 || o_ack) begin
        wait_q <= 4'h0;
      end else if (wait_q >= i_delay) begin
        o_ack     <= 1'b1;
        o_ack_vec <= first_line(i_req);
        wait_q    <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : mifb_core_model

//--- testbench.sv
// self-checking bench for the interrupt flag and enable bank
`timescale 1ns/100ps
module testbench;
  import mifb_pkg::*;
  logic                 clk;       // system clock
  logic                 rstn;      // reset, active low
  logic [3:0]           addr;      // register address
  logic [7:0]           wdata;     // write data
  logic                 wr;        // write strobe
  logic                 rd;        // read strobe
  logic [7:0]           rdata;     // read data
  logic                 pin0;      // pin 0 level
  logic                 pin1;      // pin 1 level
  mifb_events_s         evt;       // event pulses
  logic                 ack;       // vector taken
  logic [3:0]           ack_vec;   // taken vector
  logic [MIFB_NREQ-1:0] req;       // request lines
  logic                 irq;       // status interrupt
  logic                 core_en;   // core model active
  logic [3:0]           core_dly;  // core response delay
  logic [7:0]           rv;        // read value
  logic [7:0]           wd;        // written value
  logic [3:0]           vec;       // captured vector
  logic [5:0]           gl;        // group flag place of an event
  int                   bad_count; // mismatches
  int                   n_checks;  // comparisons
  // register and bit of each event, index = event bit
  logic [5:0] loc [14] = '{6'h34, 6'h35, 6'h2C, 6'h2D, 6'h2E, 6'h2F,
    6'h24, 6'h25, 6'h1F, 6'h1E, 6'h1C, 6'h17, 6'h16, 6'h0D};
  logic [7:0] wm [7] = '{8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'h33};

  always #12.5 clk = ~clk;

  mifb_bank dut_u (.i_sys_clk(clk), .i_rstn(rstn), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pin0(pin0),
    .i_pin1(pin1), .i_evt(evt), .i_ack(ack), .i_ack_vec(ack_vec),
    .o_req(req), .o_irq(irq));
  mifb_core_model core_u (.i_sys_clk(clk), .i_rstn(rstn), .i_req(req),
    .i_en(core_en), .i_delay(core_dly), .o_ack(ack), .o_ack_vec(ack_vec));

  // group flag place of an event, zero when it has none
  function automatic logic [5:0] grp_loc(input int i);
    return (i < 2) ? 6'h15 : (i < 6) ? 6'h14 : (i < 8) ? 6'h0E : 6'h00;
  endfunction : grp_loc

  // pin flag expected after an edge of the given direction
  function automatic logic [15:0] exp_pin(input int p, s, v);
    logic hit;
    hit = v ? s[0] : s[1];
    return !hit ? 16'h0000 : (p ? 16'h0020 : 16'h0010);
  endfunction : exp_pin

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic chk(input string n, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : chk

  task automatic pulse(input int i);
    @(posedge clk);
    evt <= mifb_events_s'(14'h0001 << i);
    @(posedge clk);
    evt <= '0;
  endtask : pulse

  task automatic set_pin(input int p, input logic v);
    @(posedge clk);
    if (p == 1) pin1 <= v;
    else pin0 <= v;
  endtask : set_pin

  // bounded wait for the core to take a vector
  task automatic wait_ack(output logic [3:0] v);
    v = 4'hF;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (ack) begin
        v = ack_vec;
        break;
      end
    end
  endtask : wait_ack

  task automatic done_test(input string n);
    $display("test %s done, %0d checks, %0d errors", n, n_checks, bad_count);
  endtask : done_test

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // watchdog, 20000 cycles, far beyond the few hundred cycles the tests take
  initial begin
    #(25 * 20000);
    bad_count++;
    report_and_stop();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    pin0 = 1'b0;
    pin1 = 1'b0;
    evt = '0;
    core_en = 1'b0;
    core_dly = 4'h0;
    bad_count = 0;
    n_checks = 0;
    void'($urandom(32'hE8216F89));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 9; a++) begin
      rd_reg(4'(a), rv);
      chk("reset value", 16'h0000, {8'h00, rv});
    end
    done_test("reset");
    for (int a = 0; a < 7; a++) begin
      for (int k = 0; k < 3; k++) begin
        wd = (k == 0) ? 8'hFF : 8'($urandom);
        wr_reg(4'(a), wd);
        rd_reg(4'(a), rv);
        chk("readback", {8'h00, wd & wm[a]}, {8'h00, rv});
      end
      wr_reg(4'(a), 8'h00);
    end
    wr_reg(4'h9, 8'hFF);
    rd_reg(4'h9, rv);
    chk("unmapped", 16'h0000, {8'h00, rv});
    done_test("registers");
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 4; s++) begin
        wr_reg(4'h0, 8'(s << (2 * p)));
        for (int v = 1; v >= 0; v--) begin
          set_pin(p, v[0]);
          repeat (3) @(posedge clk);
          rd_reg(p ? 4'h3 : 4'h1, rv);
          chk("pin flag", exp_pin(p, s, v), {8'h00, rv});
          wr_reg(p ? 4'h3 : 4'h1, 8'h00);
        end
      end
    end
    wr_reg(4'h0, 8'h00);
    done_test("edges");
    for (int i = 0; i < 14; i++) begin
      pulse(i);
      repeat (2) @(posedge clk);
      rd_reg({1'b0, loc[i][5:3]}, rv);
      chk("source flag", 16'h1 << loc[i][2:0], {8'h00, rv});
      gl = grp_loc(i);
      if (gl != 6'h00) begin
        rd_reg({1'b0, gl[5:3]}, rv);
        chk("group flag", 16'h1 << gl[2:0], {8'h00, rv});
        wr_reg({1'b0, gl[5:3]}, 8'h00);
      end
      wr_reg({1'b0, loc[i][5:3]}, 8'h00);
    end
    done_test("routing");
    core_en <= 1'b1;
    core_dly <= 4'($urandom_range(0, 6));
    wr_reg(4'h1, 8'h05);
    pulse(13);
    wait_ack(vec);
    chk("vector", {12'h000, 4'(MIFB_V_CMP)}, {12'h000, vec});
    repeat (2) @(posedge clk);
    rd_reg(4'h1, rv);
    chk("after service", 16'h0004, {8'h00, rv});
    pulse(13);
    repeat (3) @(posedge clk);
    #1;
    chk("held request", 16'h0000, {5'h00, req});
    rd_reg(4'h1, rv);
    chk("latched flag", 16'h0024, {8'h00, rv});
    wr_reg(4'h1, 8'h09);
    wr_reg(4'h4, 8'h03);
    pulse(7);
    wait_ack(vec);
    chk("group vector", {12'h000, 4'(MIFB_V_G0)}, {12'h000, vec});
    repeat (2) @(posedge clk);
    rd_reg(4'h1, rv);
    chk("group cleared", 16'h0008, {8'h00, rv});
    rd_reg(4'h4, rv);
    chk("sub flag kept", 16'h0023, {8'h00, rv});
    core_en <= 1'b0;
    wr_reg(4'h4, 8'h00);
    wr_reg(4'h1, 8'h01);
    pulse(13);
    repeat (3) @(posedge clk);
    #1;
    chk("disabled source", 16'h0000, {5'h00, req});
    wr_reg(4'h1, 8'h00);
    // a vector of control one, cleared through the service path
    core_en <= 1'b1;
    wr_reg(4'h2, 8'h04);
    wr_reg(4'h1, 8'h01);
    pulse(12);
    wait_ack(vec);
    chk("conv vector", {12'h000, 4'(MIFB_V_CONV)}, {12'h000, vec});
    repeat (2) @(posedge clk);
    rd_reg(4'h2, rv);
    chk("conv cleared", 16'h0004, {8'h00, rv});
    core_en <= 1'b0;
    wr_reg(4'h2, 8'h00);
    done_test("service");
    // pins, groups and service have all left their sticky bits
    rd_reg(4'h7, rv);
    chk("status events", 16'h001F, {8'h00, rv});
    wr_reg(4'h7, 8'h1F);
    pulse(1);
    repeat (2) @(posedge clk);
    rd_reg(4'h7, rv);
    chk("status", 16'h0008, {8'h00, rv});
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wr_reg(4'h8, 8'h08);
    repeat (2) @(posedge clk);
    #1;
    chk("irq raised", 16'h0001, {15'h0000, irq});
    wr_reg(4'h7, 8'h08);
    repeat (2) @(posedge clk);
    #1;
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    wr_reg(4'h8, 8'h00);
    done_test("status");
    report_and_stop();
  end
endmodule : testbench
